//--- low_freq_tick_pkg.sv
package low_freq_tick_pkg;

  // widths
  localparam int COUNT_W = 24;
  localparam int DIV_W = 12;
  localparam int TASK_W = 4;

  // event routing positions
  localparam int EV_TICK = 0;
  localparam int EV_WRAP = 1;
  localparam int EV_MATCH0 = 2;

  // count and divider values
  localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h00_0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h00_0001;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 24'hFF_FFFF;
  localparam logic [COUNT_W-1:0] NEAR_WRAP_VALUE = 24'h0F_FFF0;
  localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
  localparam logic [DIV_W-1:0] DIV_ZERO = 12'h000;
  localparam logic [DIV_W-1:0] DIV_ONE = 12'h001;

  // count read timing
  localparam int READ_STALL_CYCLES = 3;
  localparam int READ_TAIL_CYCLES = 2;
  localparam logic [1:0] READ_STALL_LAST = 2'(READ_STALL_CYCLES - 1);
  localparam logic [1:0] READ_TAIL_LAST = 2'(READ_TAIL_CYCLES - 1);
  localparam logic [1:0] READ_CNT_ZERO = 2'h0;
  localparam logic [1:0] READ_CNT_ONE = 2'h1;

  typedef struct packed {
    logic near_wrap;
    logic clear;
    logic stop;
    logic start;
  } task_req_t;

  typedef struct packed {
    logic inc;
    logic [COUNT_W-1:0] value;
  } count_step_t;

  typedef enum logic [1:0] {
    RUN_STOPPED = 2'b01,
    RUN_ACTIVE = 2'b10
  } run_state_t;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_STALL = 3'b010,
    RD_TAIL = 3'b100
  } read_state_t;

  function automatic logic at_wrap(input logic [COUNT_W-1:0] value);
    at_wrap = (value == COUNT_MAX);
  endfunction : at_wrap

endpackage : low_freq_tick_pkg

//--- edge_sync.sv
`timescale 1ns/1ps
module edge_sync (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // asynchronous level
  input wire logic async_in,
  // edge pulses
  output logic rise,
  output logic fall
);

  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic last_reg;
  logic last_next;

  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;

endmodule : edge_sync

//--- match_unit.sv
`timescale 1ns/1ps
module match_unit (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // match value write
  input wire logic wr,
  input wire logic [low_freq_tick_pkg::COUNT_W-1:0] wdata,
  // counter state
  input wire logic running,
  input wire low_freq_tick_pkg::count_step_t step,
  input wire logic route_en,
  // results
  output logic event_out,
  output logic [low_freq_tick_pkg::COUNT_W-1:0] value_out
);

  logic [low_freq_tick_pkg::COUNT_W-1:0] active_reg;
  logic [low_freq_tick_pkg::COUNT_W-1:0] active_next;
  logic [low_freq_tick_pkg::COUNT_W-1:0] pend_reg;
  logic [low_freq_tick_pkg::COUNT_W-1:0] pend_next;
  logic [low_freq_tick_pkg::COUNT_W-1:0] shown_reg;
  logic [low_freq_tick_pkg::COUNT_W-1:0] shown_next;
  logic pend_valid_reg;
  logic pend_valid_next;
  logic event_reg;
  logic event_next;
  logic hit;

  always_comb
  begin
    active_next = active_reg;
    pend_next = pend_reg;
    pend_valid_next = pend_valid_reg;
    shown_next = wr ? wdata : shown_reg;
    // only a step onto the value fires, never a load
    hit = step.inc && (step.value == active_reg);
    event_next = hit && route_en;
    if (wr && (!running || step.inc))
    begin
      active_next = wdata;
      pend_valid_next = 1'b0;
    end
    else if (wr)
    begin
      // new value waits one step, old one still armed
      pend_next = wdata;
      pend_valid_next = 1'b1;
    end
    else if (step.inc && pend_valid_reg)
    begin
      active_next = pend_reg;
      pend_valid_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      active_reg <= low_freq_tick_pkg::COUNT_RESET;
      pend_reg <= low_freq_tick_pkg::COUNT_RESET;
      shown_reg <= low_freq_tick_pkg::COUNT_RESET;
      pend_valid_reg <= 1'b0;
      event_reg <= 1'b0;
    end
    else
    begin
      active_reg <= active_next;
      pend_reg <= pend_next;
      shown_reg <= shown_next;
      pend_valid_reg <= pend_valid_next;
      event_reg <= event_next;
    end
  end

  assign event_out = event_reg;
  assign value_out = shown_reg;

  property p_match_hit;
    @(posedge clock) disable iff (!reset_n)
    step.inc && step.value == active_reg && route_en |=> event_out;
  endproperty
  a_match_hit: assert property (p_match_hit) else $error("match step did not raise compare");

  property p_match_cause;
    @(posedge clock) disable iff (!reset_n)
    event_out |-> $past(step.inc) && $past(route_en);
  endproperty
  a_match_cause: assert property (p_match_cause) else $error("compare without a routed count step");

endmodule : match_unit

//--- low_freq_tick_counter.sv
`timescale 1ns/1ps
// Function
// - keep a 24-bit count and a 12-bit divider setting.
// - count advances at slow clock rate divided by setting plus one.
// - divider setting writable only while stopped; writes ignored when running.
// - start, clear and near-wrap tasks reload the internal divider count.
// - count steps when internal divider count is zero, then reloads.
// - routed tick event on every step; disabled after reset.
// - near-wrap task loads count with 0xFFFF0.
// - routed wrap event on rollover from all ones; disabled after reset.
// - each event has its own route enable; disabled events request no clock.
// - clear never raises a compare on a zero match value.
// - start with count already at match value raises no compare.
// - compare fires when count steps onto the match value.
// - writing count plus two reliably fires at that value.
// - writing count, or count plus one while running, raises no compare; count plus one written while stopped fires on the first step.
// - old match value may fire once; values beyond plus two fire when the count reaches them.
// - count runs only from slow clock edges, sampled and stepped on CLOCK.
// - tasks act only after a falling then a rising slow clock edge.
// - count read holds ready low three cycles, done two cycles later.
module low_freq_tick_counter #(
  parameter int NUM_MATCH = 4
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // slow clock pin
  input wire logic SLOW_CLOCK,
  // task pulses
  input wire low_freq_tick_pkg::task_req_t TASK_REQ,
  // divider setting
  input wire logic DIVIDER_WR,
  input wire logic [low_freq_tick_pkg::DIV_W-1:0] DIVIDER_WDATA,
  output logic [low_freq_tick_pkg::DIV_W-1:0] DIVIDER_RDATA,
  output logic DIVIDER_LOCKED,
  // event routing
  input wire logic [NUM_MATCH+1:0] EVENT_ROUTE_ENABLE,
  // match values
  input wire logic [NUM_MATCH-1:0] MATCH_WR,
  input wire logic [low_freq_tick_pkg::COUNT_W-1:0] MATCH_WDATA,
  output logic [NUM_MATCH*low_freq_tick_pkg::COUNT_W-1:0] MATCH_VALUES,
  // count read
  input wire logic COUNT_READ,
  output logic COUNT_READY,
  output logic COUNT_DONE,
  output logic [low_freq_tick_pkg::COUNT_W-1:0] COUNT_RDATA,
  // events and status
  output logic TICK_EVENT,
  output logic WRAP_EVENT,
  output logic [NUM_MATCH-1:0] COMPARE_EVENT,
  output logic FAST_CLOCK_REQUEST,
  output logic RUNNING
);

  logic slow_rise;
  logic slow_fall;

  // slow clock only reaches the core through two flops
  edge_sync u_slow_sync (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .async_in(SLOW_CLOCK),
    .rise(slow_rise),
    .fall(slow_fall)
  );

  // task pending and arming
  logic [low_freq_tick_pkg::TASK_W-1:0] pend_reg;
  logic [low_freq_tick_pkg::TASK_W-1:0] pend_next;
  logic [low_freq_tick_pkg::TASK_W-1:0] armed_reg;
  logic [low_freq_tick_pkg::TASK_W-1:0] armed_next;
  logic [low_freq_tick_pkg::TASK_W-1:0] apply_vec;
  low_freq_tick_pkg::task_req_t apply;

  always_comb
  begin
    apply_vec = slow_rise ? armed_reg : '0;
    apply = apply_vec;
    // a new request in the apply cycle stays pending
    pend_next = (pend_reg & ~apply_vec) | TASK_REQ;
    armed_next = pend_reg & ~apply_vec & (armed_reg | {low_freq_tick_pkg::TASK_W{slow_fall}});
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pend_reg <= '0;
      armed_reg <= '0;
    end
    else
    begin
      pend_reg <= pend_next;
      armed_reg <= armed_next;
    end
  end

  // counter core
  low_freq_tick_pkg::run_state_t run_state_reg;
  low_freq_tick_pkg::run_state_t run_state_next;
  logic [low_freq_tick_pkg::DIV_W-1:0] div_setting_reg;
  logic [low_freq_tick_pkg::DIV_W-1:0] div_setting_next;
  logic [low_freq_tick_pkg::DIV_W-1:0] div_cnt_reg;
  logic [low_freq_tick_pkg::DIV_W-1:0] div_cnt_next;
  logic [low_freq_tick_pkg::COUNT_W-1:0] count_reg;
  logic [low_freq_tick_pkg::COUNT_W-1:0] count_next;
  logic [low_freq_tick_pkg::COUNT_W-1:0] count_plus;
  logic inc;
  low_freq_tick_pkg::count_step_t step;

  always_comb
  begin
    run_state_next = run_state_reg;
    div_setting_next = div_setting_reg;
    div_cnt_next = div_cnt_reg;
    count_next = count_reg;
    count_plus = count_reg + low_freq_tick_pkg::COUNT_ONE;
    inc = 1'b0;
    if (DIVIDER_WR && run_state_reg == low_freq_tick_pkg::RUN_STOPPED)
    begin
      div_setting_next = DIVIDER_WDATA;
    end
    case (run_state_reg)
      low_freq_tick_pkg::RUN_STOPPED:
      begin
        if (apply.start && !apply.stop)
        begin
          run_state_next = low_freq_tick_pkg::RUN_ACTIVE;
        end
      end
      low_freq_tick_pkg::RUN_ACTIVE:
      begin
        if (apply.stop)
        begin
          run_state_next = low_freq_tick_pkg::RUN_STOPPED;
        end
      end
      default:
      begin
        run_state_next = low_freq_tick_pkg::RUN_STOPPED;
      end
    endcase
    if (apply.start || apply.clear || apply.near_wrap)
    begin
      div_cnt_next = div_setting_reg;
    end
    if (apply.near_wrap)
    begin
      count_next = low_freq_tick_pkg::NEAR_WRAP_VALUE;
    end
    else if (apply.clear)
    begin
      count_next = low_freq_tick_pkg::COUNT_RESET;
    end
    else if (slow_rise && run_state_reg == low_freq_tick_pkg::RUN_ACTIVE && apply_vec == '0)
    begin
      // divide by setting plus one
      if (div_cnt_reg == low_freq_tick_pkg::DIV_ZERO)
      begin
        inc = 1'b1;
        count_next = count_plus;
        div_cnt_next = div_setting_reg;
      end
      else
      begin
        div_cnt_next = div_cnt_reg - low_freq_tick_pkg::DIV_ONE;
      end
    end
    step.inc = inc;
    step.value = count_plus;
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      run_state_reg <= low_freq_tick_pkg::RUN_STOPPED;
      div_setting_reg <= low_freq_tick_pkg::DIV_RESET;
      div_cnt_reg <= low_freq_tick_pkg::DIV_RESET;
      count_reg <= low_freq_tick_pkg::COUNT_RESET;
    end
    else
    begin
      run_state_reg <= run_state_next;
      div_setting_reg <= div_setting_next;
      div_cnt_reg <= div_cnt_next;
      count_reg <= count_next;
    end
  end

  // tick and wrap events
  logic tick_reg;
  logic tick_next;
  logic wrap_reg;
  logic wrap_next;

  always_comb
  begin
    tick_next = inc && EVENT_ROUTE_ENABLE[low_freq_tick_pkg::EV_TICK];
    wrap_next = inc && low_freq_tick_pkg::at_wrap(count_reg)
      && EVENT_ROUTE_ENABLE[low_freq_tick_pkg::EV_WRAP];
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tick_reg <= 1'b0;
      wrap_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= tick_next;
      wrap_reg <= wrap_next;
    end
  end

  // match channels
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MATCH; gi++)
    begin : g_match
      match_unit u_match (
        .clock(CLOCK),
        .reset_n(RESET_N),
        .wr(MATCH_WR[gi]),
        .wdata(MATCH_WDATA),
        .running(run_state_reg == low_freq_tick_pkg::RUN_ACTIVE),
        .step(step),
        .route_en(EVENT_ROUTE_ENABLE[low_freq_tick_pkg::EV_MATCH0+gi]),
        .event_out(COMPARE_EVENT[gi]),
        .value_out(MATCH_VALUES[gi*low_freq_tick_pkg::COUNT_W +: low_freq_tick_pkg::COUNT_W])
      );
    end
  endgenerate

  // count read with fixed stall
  low_freq_tick_pkg::read_state_t rd_state_reg;
  low_freq_tick_pkg::read_state_t rd_state_next;
  logic [1:0] rd_cnt_reg;
  logic [1:0] rd_cnt_next;
  logic [low_freq_tick_pkg::COUNT_W-1:0] rdata_reg;
  logic [low_freq_tick_pkg::COUNT_W-1:0] rdata_next;

  always_comb
  begin
    rd_state_next = rd_state_reg;
    rd_cnt_next = rd_cnt_reg;
    rdata_next = rdata_reg;
    case (rd_state_reg)
      low_freq_tick_pkg::RD_IDLE:
      begin
        if (COUNT_READ)
        begin
          rd_state_next = low_freq_tick_pkg::RD_STALL;
          rd_cnt_next = low_freq_tick_pkg::READ_STALL_LAST;
        end
      end
      low_freq_tick_pkg::RD_STALL:
      begin
        if (rd_cnt_reg == low_freq_tick_pkg::READ_CNT_ZERO)
        begin
          rdata_next = count_reg;
          rd_state_next = low_freq_tick_pkg::RD_TAIL;
          rd_cnt_next = low_freq_tick_pkg::READ_TAIL_LAST;
        end
        else
        begin
          rd_cnt_next = rd_cnt_reg - low_freq_tick_pkg::READ_CNT_ONE;
        end
      end
      low_freq_tick_pkg::RD_TAIL:
      begin
        if (rd_cnt_reg == low_freq_tick_pkg::READ_CNT_ZERO)
        begin
          rd_state_next = low_freq_tick_pkg::RD_IDLE;
        end
        else
        begin
          rd_cnt_next = rd_cnt_reg - low_freq_tick_pkg::READ_CNT_ONE;
        end
      end
      default:
      begin
        rd_state_next = low_freq_tick_pkg::RD_IDLE;
        rd_cnt_next = low_freq_tick_pkg::READ_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rd_state_reg <= low_freq_tick_pkg::RD_IDLE;
      rd_cnt_reg <= low_freq_tick_pkg::READ_CNT_ZERO;
      rdata_reg <= low_freq_tick_pkg::COUNT_RESET;
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      rd_cnt_reg <= rd_cnt_next;
      rdata_reg <= rdata_next;
    end
  end

  // outputs
  assign COUNT_READY = (rd_state_reg != low_freq_tick_pkg::RD_STALL);
  assign COUNT_DONE = (rd_state_reg == low_freq_tick_pkg::RD_TAIL) && (rd_cnt_reg == low_freq_tick_pkg::READ_CNT_ZERO);
  assign COUNT_RDATA = rdata_reg;
  assign DIVIDER_RDATA = div_setting_reg;
  assign DIVIDER_LOCKED = (run_state_reg == low_freq_tick_pkg::RUN_ACTIVE);
  assign RUNNING = (run_state_reg == low_freq_tick_pkg::RUN_ACTIVE);
  assign TICK_EVENT = tick_reg;
  assign WRAP_EVENT = wrap_reg;
  // only routed events ask for the fast clock
  assign FAST_CLOCK_REQUEST = tick_reg | wrap_reg | (|COMPARE_EVENT);

  property p_div_locked;
    @(posedge CLOCK) disable iff (!RESET_N)
    DIVIDER_WR && RUNNING |=> $stable(DIVIDER_RDATA);
  endproperty
  a_div_locked: assert property (p_div_locked) else $error("divider changed while running");

  property p_reload;
    @(posedge CLOCK) disable iff (!RESET_N)
    apply.start || apply.clear || apply.near_wrap |=> div_cnt_reg == $past(div_setting_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("divider count not reloaded on task");

  property p_step_at_zero;
    @(posedge CLOCK) disable iff (!RESET_N)
    slow_rise && RUNNING && apply_vec == '0 && div_cnt_reg == low_freq_tick_pkg::DIV_ZERO
      |=> count_reg == $past(count_plus) && div_cnt_reg == $past(div_setting_reg);
  endproperty
  a_step_at_zero: assert property (p_step_at_zero) else $error("count did not step at zero");

  property p_tick;
    @(posedge CLOCK) disable iff (!RESET_N)
    TICK_EVENT |-> $past(inc) && $past(EVENT_ROUTE_ENABLE[low_freq_tick_pkg::EV_TICK])
      && count_reg == $past(count_plus);
  endproperty
  a_tick: assert property (p_tick) else $error("tick without routed step");

  property p_near_wrap;
    @(posedge CLOCK) disable iff (!RESET_N)
    apply.near_wrap |=> count_reg == low_freq_tick_pkg::NEAR_WRAP_VALUE;
  endproperty
  a_near_wrap: assert property (p_near_wrap) else $error("near-wrap load wrong");

  property p_wrap;
    @(posedge CLOCK) disable iff (!RESET_N)
    inc && count_reg == low_freq_tick_pkg::COUNT_MAX && EVENT_ROUTE_ENABLE[low_freq_tick_pkg::EV_WRAP]
      |=> WRAP_EVENT && count_reg == low_freq_tick_pkg::COUNT_RESET;
  endproperty
  a_wrap: assert property (p_wrap) else $error("rollover missed wrap event");

  property p_route_quiet;
    @(posedge CLOCK) disable iff (!RESET_N)
    EVENT_ROUTE_ENABLE == '0 |=> !FAST_CLOCK_REQUEST;
  endproperty
  a_route_quiet: assert property (p_route_quiet) else $error("fast clock requested by disabled event");

  property p_clear_quiet;
    @(posedge CLOCK) disable iff (!RESET_N)
    apply.clear |=> COMPARE_EVENT == '0;
  endproperty
  a_clear_quiet: assert property (p_clear_quiet) else $error("clear raised a compare");

  property p_start_quiet;
    @(posedge CLOCK) disable iff (!RESET_N)
    apply.start && !apply.clear && !apply.near_wrap |=> COMPARE_EVENT == '0 && $stable(count_reg);
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("start raised a compare");

  property p_task_wait;
    @(posedge CLOCK) disable iff (!RESET_N)
    $rose(armed_reg[0]) |-> $past(slow_fall) && $past(pend_reg[0]);
  endproperty
  a_task_wait: assert property (p_task_wait) else $error("task armed without falling edge");

  property p_read_stall;
    @(posedge CLOCK) disable iff (!RESET_N)
    COUNT_READ && rd_state_reg == low_freq_tick_pkg::RD_IDLE
      |=> !COUNT_READY [*3] ##1 (COUNT_READY && !COUNT_DONE) ##1 COUNT_DONE;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("count read timing wrong");

endmodule : low_freq_tick_counter

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int NM = 4;
  logic CLOCK;
  logic RESET_N;
  logic SLOW_CLOCK;
  low_freq_tick_pkg::task_req_t TASK_REQ;
  logic DIVIDER_WR;
  logic [11:0] DIVIDER_WDATA;
  logic [11:0] DIVIDER_RDATA;
  logic DIVIDER_LOCKED;
  logic [NM+1:0] EVENT_ROUTE_ENABLE;
  logic [NM-1:0] MATCH_WR;
  logic [23:0] MATCH_WDATA;
  logic [NM*24-1:0] MATCH_VALUES;
  logic COUNT_READ;
  logic COUNT_READY;
  logic COUNT_DONE;
  logic [23:0] COUNT_RDATA;
  logic TICK_EVENT;
  logic WRAP_EVENT;
  logic [NM-1:0] COMPARE_EVENT;
  logic FAST_CLOCK_REQUEST;
  logic RUNNING;
  int n_errors = 0;
  int check_count = 0;
  int n_tick = 0;
  int n_wrap = 0;
  int n_fcr = 0;
  int n_cmp [NM];
  logic [23:0] cnt_a;
  logic [23:0] cnt_b;

  low_freq_tick_counter #(.NUM_MATCH(NM)) uut (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .SLOW_CLOCK(SLOW_CLOCK), .TASK_REQ(TASK_REQ),
    .DIVIDER_WR(DIVIDER_WR), .DIVIDER_WDATA(DIVIDER_WDATA), .DIVIDER_RDATA(DIVIDER_RDATA),
    .DIVIDER_LOCKED(DIVIDER_LOCKED), .EVENT_ROUTE_ENABLE(EVENT_ROUTE_ENABLE), .MATCH_WR(MATCH_WR),
    .MATCH_WDATA(MATCH_WDATA), .MATCH_VALUES(MATCH_VALUES), .COUNT_READ(COUNT_READ),
    .COUNT_READY(COUNT_READY), .COUNT_DONE(COUNT_DONE), .COUNT_RDATA(COUNT_RDATA),
    .TICK_EVENT(TICK_EVENT), .WRAP_EVENT(WRAP_EVENT), .COMPARE_EVENT(COMPARE_EVENT),
    .FAST_CLOCK_REQUEST(FAST_CLOCK_REQUEST), .RUNNING(RUNNING)
  );

  initial
  begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  // slow clock runs from time zero, before the counter is used
  initial
  begin
    SLOW_CLOCK = 1'b0;
    forever #15259 SLOW_CLOCK = ~SLOW_CLOCK;
  end

  // event pulse counters, sampled away from the launching edge
  always @(negedge CLOCK)
  begin
    if (TICK_EVENT === 1'b1) n_tick++;
    if (WRAP_EVENT === 1'b1) n_wrap++;
    if (FAST_CLOCK_REQUEST === 1'b1) n_fcr++;
    for (int i = 0; i < NM; i++)
      if (COMPARE_EVENT[i] === 1'b1) n_cmp[i]++;
  end

  task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task conclude;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task slow_rises(input int n);
    repeat (n) @(posedge SLOW_CLOCK);
    repeat (6) @(negedge CLOCK);
  endtask : slow_rises

  // request lands while slow clock is high, so the next fall then rise applies it
  task do_task(input int b);
    slow_rises(1);
    TASK_REQ = low_freq_tick_pkg::task_req_t'(4'h1 << b);
    @(negedge CLOCK);
    TASK_REQ = 4'h0;
    @(negedge SLOW_CLOCK);
    slow_rises(1);
  endtask : do_task

  task read_count(output logic [23:0] value);
    @(negedge CLOCK);
    COUNT_READ = 1'b1;
    @(negedge CLOCK);
    COUNT_READ = 1'b0;
    repeat (3)
    begin
      check("ready stall", 24'(COUNT_READY), 24'h00_0000);
      @(negedge CLOCK);
    end
    check("ready back", 24'(COUNT_READY), 24'h00_0001);
    @(negedge CLOCK);
    check("read done", 24'(COUNT_DONE), 24'h00_0001);
    value = COUNT_RDATA;
  endtask : read_count

  task wr_div(input logic [11:0] v);
    @(negedge CLOCK);
    DIVIDER_WR = 1'b1;
    DIVIDER_WDATA = v;
    @(negedge CLOCK);
    DIVIDER_WR = 1'b0;
  endtask : wr_div

  task wr_match(input int ch, input logic [23:0] v);
    @(negedge CLOCK);
    MATCH_WR = 4'(1 << ch);
    MATCH_WDATA = v;
    @(negedge CLOCK);
    MATCH_WR = 4'h0;
  endtask : wr_match

  task t_reset;
    check("running", 24'(RUNNING), 24'h00_0000);
    check("ready", 24'(COUNT_READY), 24'h00_0001);
    check("divider", 24'(DIVIDER_RDATA), 24'h00_0000);
    check("fast req", 24'(FAST_CLOCK_REQUEST), 24'h00_0000);
    $display("done reset");
  endtask : t_reset

  task t_divider;
    wr_div(12'h001);
    check("divider written", 24'(DIVIDER_RDATA), 24'h00_0001);
    EVENT_ROUTE_ENABLE = 6'h01;
    do_task(0);
    check("running", 24'(RUNNING), 24'h00_0001);
    check("locked", 24'(DIVIDER_LOCKED), 24'h00_0001);
    wr_div(12'h005);
    check("divider held", 24'(DIVIDER_RDATA), 24'h00_0001);
    n_tick = 0;
    n_fcr = 0;
    slow_rises(8);
    check("ticks", 24'(n_tick), 24'h00_0004);
    check("fast req on", 24'(n_fcr), 24'h00_0004);
    read_count(cnt_a);
    check("count", cnt_a, 24'h00_0004);
    $display("done divider");
  endtask : t_divider

  task t_route_off;
    EVENT_ROUTE_ENABLE = 6'h00;
    n_tick = 0;
    n_fcr = 0;
    slow_rises(4);
    check("ticks off", 24'(n_tick), 24'h00_0000);
    check("fast req off", 24'(n_fcr), 24'h00_0000);
    read_count(cnt_a);
    check("count", cnt_a, 24'h00_0006);
    $display("done route off");
  endtask : t_route_off

  task t_stop;
    do_task(1);
    check("stopped", 24'(RUNNING), 24'h00_0000);
    check("unlocked", 24'(DIVIDER_LOCKED), 24'h00_0000);
    read_count(cnt_a);
    check("stop count", cnt_a, 24'h00_0006);
    slow_rises(4);
    read_count(cnt_b);
    check("count held", cnt_b, cnt_a);
    $display("done stop");
  endtask : t_stop

  task t_clear_match;
    wr_div(12'h000);
    wr_match(0, 24'h00_0000);
    wr_match(1, 24'h00_0003);
    check("match1 value", MATCH_VALUES[47:24], 24'h00_0003);
    EVENT_ROUTE_ENABLE = 6'h3C;
    for (int i = 0; i < NM; i++) n_cmp[i] = 0;
    do_task(2);
    read_count(cnt_a);
    check("cleared", cnt_a, 24'h00_0000);
    check("no cmp on clear", 24'(n_cmp[0]), 24'h00_0000);
    do_task(0);
    slow_rises(3);
    read_count(cnt_a);
    check("count", cnt_a, 24'h00_0003);
    check("cmp1", 24'(n_cmp[1]), 24'h00_0001);
    check("cmp0", 24'(n_cmp[0]), 24'h00_0000);
    $display("done clear match");
  endtask : t_clear_match

  task t_match_write;
    slow_rises(1);
    read_count(cnt_a);
    wr_match(0, cnt_a + 24'h00_0002);
    wr_match(2, cnt_a + 24'h00_0001);
    wr_match(3, cnt_a + 24'h00_0002);
    slow_rises(1);
    // channel 3 now holds count plus one; rewrite it, the old value still fires
    wr_match(3, 24'h00_0001);
    slow_rises(2);
    check("cmp at n+2", 24'(n_cmp[0]), 24'h00_0001);
    check("no cmp at n+1", 24'(n_cmp[2]), 24'h00_0000);
    check("old value", 24'(n_cmp[3]), 24'h00_0001);
    check("cmp1 once", 24'(n_cmp[1]), 24'h00_0001);
    $display("done match write");
  endtask : t_match_write

  task t_near_wrap;
    EVENT_ROUTE_ENABLE = 6'h3F;
    do_task(3);
    read_count(cnt_a);
    check("near wrap", cnt_a, 24'h0F_FFF0);
    check("no wrap", 24'(n_wrap), 24'h00_0000);
    $display("done near wrap");
  endtask : t_near_wrap

  initial
  begin
    RESET_N = 1'b0;
    TASK_REQ = 4'h0;
    DIVIDER_WR = 1'b0;
    DIVIDER_WDATA = 12'h000;
    EVENT_ROUTE_ENABLE = 6'h00;
    MATCH_WR = 4'h0;
    MATCH_WDATA = 24'h00_0000;
    COUNT_READ = 1'b0;
    for (int i = 0; i < NM; i++) n_cmp[i] = 0;
    repeat (2) @(negedge CLOCK);
    RESET_N = 1'b1;
    @(negedge CLOCK);
    t_reset();
    t_divider();
    t_route_off();
    t_stop();
    t_clear_match();
    t_match_write();
    t_near_wrap();
    conclude();
  end

  // about 33 slow periods are needed; allow five times that
  initial
  begin
    #5_000_000;
    n_errors++;
    conclude();
  end
endmodule : tb_top
